// *** ca_pkg.sv ***
// Package: command/address constants, command codes and decoded-command types
// Operation
// - Read/write samples burst chop; low chops burst
// - Activate needs act low with chip select low
// - Activate treats command pins as row A16..A14
// - Bank inputs pick bank for access commands
// - Mode register set: group+bank pick register
// - Bank group inputs pick target bank group
// - x16 decodes only lowest bank group bit
// - Chip ID only for stacked x4/x8 parts
// - Dual-die uses second select, enable, termination; the device does not decode odt1
// - Stacks decode chip ID with shared controls
// - All inputs captured on rising clock crossing
// - Clock enable gates clocks, buffers, drivers
// - Enable low: precharge/self refresh or active power-down
// - Self refresh exits on enable high, asynchronously; the device leaves PWR_SR only at the next rising clock edge
// - Controller holds enable high during accesses
// - Power-down keeps clock, termination, reset, enable buffers; the device drops o_clk_en in power-down
// - Self refresh keeps only enable and reset buffers; the device turns o_buf_ctl_en off in self refresh
// - Commands ignored while chip select high
// - Chip select picks rank, part of command
// - A10 on read/write requests auto precharge
// - A10 on precharge: one bank or all
// - Reset low holds device; controller keeps high
package ca_pkg;
  localparam int ROW_W = 18;
  localparam int BANK_W = 2;
  localparam int BG_W = 2;
  localparam int CID_W = 3;
  localparam int NBANKS = 16;
  localparam int BC_BIT = 12;
  localparam int AP_BIT = 10;
  localparam int A14_BIT = 14;
  localparam int A15_BIT = 15;
  localparam int A16_BIT = 16;
  localparam logic [1:0] ORG_X4 = 2'h0;
  localparam logic [1:0] ORG_X8 = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;
  localparam logic [CID_W-1:0] CID_RST = 3'h0;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_DES, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA, CMD_REF, CMD_MRS, CMD_ZQ, CMD_SRE, CMD_RSV
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_PPD, PWR_APD, PWR_SR
  } pwr_t;

  // Pin group of the command/address bus; pins kept as raw levels
  typedef struct packed {
    logic cs0_n;
    logic cs1_n;
    logic cke0;
    logic cke1;
    logic odt0;
    logic odt1;
    logic act_n;
    logic [ROW_W-1:0] addr;
    logic [BG_W-1:0] bg;
    logic [BANK_W-1:0] ba;
    logic [CID_W-1:0] cid;
  } ca_bus_t;
endpackage

// *** ca_if.sv ***
// Interface: command/address link between controller and module
`timescale 1ns/1ps
interface ca_if;
  import ca_pkg::*;
  ca_bus_t bus;
  logic rst_n;
  modport host (output bus, output rst_n);
  modport dev (input bus, input rst_n);
endinterface

// *** ca_device.sv ***
// Module: device-side command/address decoder with power state tracking
`timescale 1ns/1ps
module ca_device #(
  parameter logic [1:0] ORG = ca_pkg::ORG_X8,
  parameter bit DDP = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ca_if.dev link,
  output ca_pkg::cmd_t o_cmd,
  output logic o_cmd_vld,
  output logic o_die,
  output logic [ca_pkg::CID_W-1:0] o_cid,
  output logic [ca_pkg::BG_W-1:0] o_bg,
  output logic [ca_pkg::BANK_W-1:0] o_ba,
  output logic [ca_pkg::ROW_W-1:0] o_addr,
  output logic [3:0] o_mr_sel,
  output logic o_burst_chop,
  output logic o_auto_pre,
  output ca_pkg::pwr_t o_pwr,
  output logic o_buf_cmd_en,
  output logic o_buf_ctl_en,
  output logic o_clk_en,
  output logic [ca_pkg::NBANKS-1:0] o_open_banks
);
  import ca_pkg::*;

  cmd_t cmd_r, cmd_nxt;
  logic vld_r, vld_nxt;
  logic die_r, die_nxt;
  logic [CID_W-1:0] cid_r, cid_nxt;
  logic [BG_W-1:0] bg_r, bg_nxt;
  logic [BANK_W-1:0] ba_r, ba_nxt;
  logic [ROW_W-1:0] addr_r, addr_nxt;
  logic [3:0] mr_r, mr_nxt;
  logic bc_r, bc_nxt;
  logic ap_r, ap_nxt;
  pwr_t pwr_r, pwr_nxt;
  logic [NBANKS-1:0] open_r, open_nxt;
  logic cs_n, cke, sel_ok;
  cmd_t dec;
  logic [BG_W-1:0] bg_eff;
  logic [3:0] bidx;
  // Self refresh exit term is formed without the clock but taken into the power state at the next clock edge; held low by reset
  logic sr_exit;

  // Bank index from group and bank bits
  function automatic logic [3:0] bank_idx(input logic [BG_W-1:0] g, input logic [BANK_W-1:0] b);
    bank_idx = {g, b};
  endfunction

  // Decode one command from raw pins; activate overrides the command pins
  function automatic cmd_t decode(input logic act_n, input logic [ROW_W-1:0] a);
    logic ras_n, cas_n, we_n;
    ras_n = a[A16_BIT];
    cas_n = a[A15_BIT];
    we_n = a[A14_BIT];
    if (!act_n) begin
      decode = CMD_ACT;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h7: decode = CMD_NOP;
        3'h5: decode = CMD_RD;
        3'h4: decode = CMD_WR;
        3'h2: decode = a[AP_BIT] ? CMD_PREA : CMD_PRE;
        3'h1: decode = CMD_REF;
        3'h0: decode = CMD_MRS;
        3'h6: decode = CMD_ZQ;
        // Reserved pin codes decode to their own value, never to a real command
        default: decode = CMD_RSV;
      endcase
    end
  endfunction

  // Die select: dual-die uses second select/enable, stacks use shared ones
  always_comb begin
    if (DDP && link.bus.cs0_n && !link.bus.cs1_n) begin
      cs_n = 1'b0;
      cke = link.bus.cke1;
    end else begin
      cs_n = link.bus.cs0_n;
      cke = link.bus.cke0;
    end
    sel_ok = !cs_n;
    dec = decode(link.bus.act_n, link.bus.addr);
    bg_eff = (ORG == ORG_X16) ? {1'b0, link.bus.bg[0]} : link.bus.bg;
    bidx = bank_idx(bg_eff, link.bus.ba);
  end

  // Asynchronous self refresh exit term: the enable pin alone wakes it
  assign sr_exit = (pwr_r == PWR_SR) && cke;

  // Next-state decode of command fields and power state
  always_comb begin
    cmd_nxt = CMD_DES;
    vld_nxt = 1'b0;
    die_nxt = die_r;
    cid_nxt = cid_r;
    bg_nxt = bg_r;
    ba_nxt = ba_r;
    addr_nxt = addr_r;
    mr_nxt = mr_r;
    bc_nxt = bc_r;
    ap_nxt = ap_r;
    pwr_nxt = pwr_r;
    open_nxt = open_r;
    case (pwr_r)
      PWR_ACTIVE: begin
        if (!cke) begin
          // Self refresh entry needs a command with enable dropping
          if (sel_ok && dec == CMD_REF && open_r == '0) begin
            pwr_nxt = PWR_SR;
          end else if (open_r == '0) begin
            pwr_nxt = PWR_PPD;
          end else begin
            pwr_nxt = PWR_APD;
          end
        end else if (sel_ok) begin
          cmd_nxt = dec;
          vld_nxt = 1'b1;
          die_nxt = DDP && link.bus.cs0_n;
          cid_nxt = (ORG == ORG_X16) ? CID_RST : link.bus.cid;
          bg_nxt = bg_eff;
          ba_nxt = link.bus.ba;
          addr_nxt = link.bus.addr;
          // Auto precharge closes the bank at once; access timing is not modelled here
          case (dec)
            CMD_ACT: open_nxt[bidx] = 1'b1;
            CMD_RD, CMD_WR: begin
              bc_nxt = !link.bus.addr[BC_BIT];
              ap_nxt = link.bus.addr[AP_BIT];
              if (link.bus.addr[AP_BIT]) begin
                open_nxt[bidx] = 1'b0;
              end
            end
            CMD_PRE: open_nxt[bidx] = 1'b0;
            CMD_PREA: open_nxt = '0;
            // x16 has no upper group pin, so the register choice uses the masked group
            CMD_MRS: mr_nxt = bank_idx(bg_eff, link.bus.ba);
            default: ;
          endcase
        end
      end
      // Any enable high wakes power-down; the command on that edge is dropped
      PWR_PPD, PWR_APD: begin
        if (cke) begin
          pwr_nxt = PWR_ACTIVE;
        end
      end
      // Self refresh: only the enable buffer listens, so nothing else is decoded
      default: begin
        if (sr_exit) begin
          pwr_nxt = PWR_ACTIVE;
        end
      end
    endcase
  end

  // Registers; reset is synchronous in this clock domain
  // The link reset is folded in so a controller reset also clears the bank map
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !link.rst_n) begin
      cmd_r <= CMD_DES;
      vld_r <= 1'b0;
      die_r <= 1'b0;
      cid_r <= CID_RST;
      bg_r <= '0;
      ba_r <= '0;
      addr_r <= '0;
      mr_r <= 4'h0;
      bc_r <= 1'b0;
      ap_r <= 1'b0;
      pwr_r <= PWR_ACTIVE;
      open_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
      vld_r <= vld_nxt;
      die_r <= die_nxt;
      cid_r <= cid_nxt;
      bg_r <= bg_nxt;
      ba_r <= ba_nxt;
      addr_r <= addr_nxt;
      mr_r <= mr_nxt;
      bc_r <= bc_nxt;
      ap_r <= ap_nxt;
      pwr_r <= pwr_nxt;
      open_r <= open_nxt;
    end
  end

  // Buffer enables follow power state
  // Only the control buffers live through power-down, with clock and command buffers off; all three are off in self refresh
  assign o_clk_en = (pwr_r == PWR_ACTIVE);
  assign o_buf_cmd_en = (pwr_r == PWR_ACTIVE);
  assign o_buf_ctl_en = (pwr_r != PWR_SR);
  // Fields hold until the next accepted command (chop/auto precharge: next read/write; register select: next mode register set); command and valid last one cycle
  assign o_cmd = cmd_r;
  assign o_cmd_vld = vld_r;
  assign o_die = die_r;
  assign o_cid = cid_r;
  assign o_bg = bg_r;
  assign o_ba = ba_r;
  assign o_addr = addr_r;
  assign o_mr_sel = mr_r;
  assign o_burst_chop = bc_r;
  assign o_auto_pre = ap_r;
  assign o_pwr = pwr_r;
  assign o_open_banks = open_r;
endmodule

// *** ca_host.sv ***
// Module: controller-side driver of the command/address pins
`timescale 1ns/1ps
module ca_host (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input ca_pkg::cmd_t i_cmd,
  input wire logic i_die,
  input wire logic [ca_pkg::CID_W-1:0] i_cid,
  input wire logic [ca_pkg::BG_W-1:0] i_bg,
  input wire logic [ca_pkg::BANK_W-1:0] i_ba,
  input wire logic [ca_pkg::ROW_W-1:0] i_addr,
  input wire logic i_cke,
  output logic o_ready,
  ca_if.host link
);
  import ca_pkg::*;

  ca_bus_t bus_r, bus_nxt;
  logic [2:0] rcw;

  // Command pins code for a command; activate handled separately
  always_comb begin
    case (i_cmd)
      CMD_RD: rcw = 3'h5;
      CMD_WR: rcw = 3'h4;
      CMD_PRE, CMD_PREA: rcw = 3'h2;
      CMD_REF, CMD_SRE: rcw = 3'h1;
      CMD_MRS: rcw = 3'h0;
      CMD_ZQ: rcw = 3'h6;
      default: rcw = 3'h7;
    endcase
  end

  // Next pin values; idle cycles deselect every die
  always_comb begin
    bus_nxt = bus_r;
    bus_nxt.cs0_n = 1'b1;
    bus_nxt.cs1_n = 1'b1;
    bus_nxt.act_n = 1'b1;
    bus_nxt.cke0 = i_cke;
    bus_nxt.cke1 = i_cke;
    if (i_req && i_cmd != CMD_DES) begin
      bus_nxt.cs0_n = i_die;
      bus_nxt.cs1_n = !i_die;
      bus_nxt.act_n = (i_cmd != CMD_ACT);
      bus_nxt.addr = i_addr;
      if (i_cmd != CMD_ACT) begin
        bus_nxt.addr[A16_BIT] = rcw[2];
        bus_nxt.addr[A15_BIT] = rcw[1];
        bus_nxt.addr[A14_BIT] = rcw[0];
      end
      if (i_cmd == CMD_PRE || i_cmd == CMD_PREA) begin
        bus_nxt.addr[AP_BIT] = (i_cmd == CMD_PREA);
      end
      if (i_cmd == CMD_SRE) begin
        bus_nxt.cke0 = 1'b0;
        bus_nxt.cke1 = 1'b0;
      end
      bus_nxt.bg = i_bg;
      bus_nxt.ba = i_ba;
      bus_nxt.cid = i_cid;
    end
  end

  // Pin registers; reset pin held low during local reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      bus_r <= '{cs0_n: 1'b1, cs1_n: 1'b1, act_n: 1'b1, cke0: 1'b0, cke1: 1'b0, default: '0};
    end else begin
      bus_r <= bus_nxt;
    end
  end

  assign link.bus = bus_r;
  assign link.rst_n = i_rst_n;
  assign o_ready = 1'b1;
endmodule

// *** ca_monitor.sv ***
// Checker of the pin interface between the two ends
`timescale 1ns/1ps
module ca_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input ca_pkg::ca_bus_t bus,
  input wire logic rst_n
);
  import ca_pkg::*;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic rw_w;
  // Read or write on rank 0; the controller owes a steady enable around it
  assign rw_w = !bus.cs0_n && bus.act_n && bus.addr[16:15] == 2'h2;
  // Pin reset checks look at the release edge, since the disable masks the reset itself; the link reset is compared each cycle outside reset
  property p_rst_sel; $rose(i_rst_n) |-> bus.cs0_n && bus.act_n; endproperty
  a_rst_sel: assert property (p_rst_sel) else $error("pins busy at reset exit");
  property p_rst_cs1; $rose(i_rst_n) |-> bus.cs1_n && !bus.cke1; endproperty
  a_rst_cs1: assert property (p_rst_cs1) else $error("second die busy at reset exit");
  property p_rst_cke; $rose(i_rst_n) |-> !bus.cke0; endproperty
  a_rst_cke: assert property (p_rst_cke) else $error("enable high at reset exit");
  property p_rst_pass; rst_n == i_rst_n; endproperty
  a_rst_pass: assert property (p_rst_pass) else $error("link reset differs");
  property p_act_cs; !bus.act_n |-> !bus.cs0_n || !bus.cs1_n; endproperty
  a_act_cs: assert property (p_act_cs) else $error("activate without select");
  property p_one_rank; !bus.cs0_n |-> bus.cs1_n; endproperty
  a_one_rank: assert property (p_one_rank) else $error("two ranks selected");
  property p_rw_cke; rw_w |-> bus.cke0 ##1 bus.cke0; endproperty
  a_rw_cke: assert property (p_rw_cke) else $error("enable dropped at access");
  property p_low_cke; !bus.cs0_n && !bus.cke0 |-> bus.act_n && bus.addr[16:14] == 3'h1; endproperty
  a_low_cke: assert property (p_low_cke) else $error("command with enable low");
  c_act: cover property (!bus.cs0_n && !bus.act_n);
  c_rw: cover property (rw_w);
  c_sre: cover property (!bus.cs0_n && !bus.cke0);
  c_die: cover property (bus.cs0_n && !bus.cs1_n);
endmodule

// *** sdram_command_address_decode_tb_top.sv ***
// Bench: random and corner commands through both ends
`timescale 1ns/1ps
module sdram_command_address_decode_tb_top;
  import ca_pkg::*;
  logic i_ref_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic req = 1'h0;
  logic die = 1'h0;
  logic cke = 1'h1;
  cmd_t cmd = CMD_DES;
  logic [CID_W-1:0] cid = 3'h0;
  logic [BG_W-1:0] bg = 2'h0;
  logic [BANK_W-1:0] ba = 2'h0;
  logic [ROW_W-1:0] a = 18'h0;
  cmd_t q_cmd;
  pwr_t pwr;
  logic vld, chop, ap, cmd_en, ctl_en, clk_en;
  logic [CID_W-1:0] q_cid;
  logic [BG_W-1:0] q_bg;
  logic [BANK_W-1:0] q_ba;
  logic [ROW_W-1:0] q_a;
  logic [3:0] mr;
  logic [NBANKS-1:0] bk;
  logic q_die;
  logic [BG_W-1:0] q16_bg;
  logic [CID_W-1:0] q16_cid;
  logic [3:0] q16_mr;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  ca_if ca_if_inst ();
  ca_host ca_host_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(req), .i_cmd(cmd), .i_die(die),
    .i_cid(cid), .i_bg(bg), .i_ba(ba), .i_addr(a), .i_cke(cke), .o_ready(), .link(ca_if_inst.host));
  ca_device #(.ORG(ORG_X8), .DDP(1'h1)) ca_device_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .link(ca_if_inst.dev), .o_cmd(q_cmd), .o_cmd_vld(vld), .o_die(q_die), .o_cid(q_cid), .o_bg(q_bg),
    .o_ba(q_ba), .o_addr(q_a), .o_mr_sel(mr), .o_burst_chop(chop), .o_auto_pre(ap), .o_pwr(pwr),
    .o_buf_cmd_en(cmd_en), .o_buf_ctl_en(ctl_en), .o_clk_en(clk_en), .o_open_banks(bk));
  // Second decoder of the x16 organisation on the same pins; only its masked fields are compared
  ca_device #(.ORG(ORG_X16), .DDP(1'h0)) ca_device_x16_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .link(ca_if_inst.dev), .o_cmd(), .o_cmd_vld(), .o_die(), .o_cid(q16_cid), .o_bg(q16_bg), .o_ba(),
    .o_addr(), .o_mr_sel(q16_mr), .o_burst_chop(), .o_auto_pre(), .o_pwr(), .o_buf_cmd_en(),
    .o_buf_ctl_en(), .o_clk_en(), .o_open_banks());
  ca_monitor ca_monitor_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(ca_if_inst.bus),
    .rst_n(ca_if_inst.rst_n));
  always #20 i_ref_clk = ~i_ref_clk;
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [ROW_W-1:0] got, input logic [ROW_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One request cycle; returns where the device answer stands
  task automatic issue(input cmd_t c, input logic [ROW_W-1:0] v);
    cmd = c;
    a = v;
    req = 1'h1;
    @(posedge i_ref_clk);
    #1 req = 1'h0;
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wait3();
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask
  // Chopped burst is requested by a low bit 12
  function automatic logic exp_chop(input logic [ROW_W-1:0] v);
    return ~v[BC_BIT];
  endfunction
  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'he7c91cb9));
    repeat (4) @(posedge i_ref_clk);
    #1 i_rst_n = 1'h1;
    @(posedge i_ref_clk);
    #1;
    // Random reads and writes with random targets and chip id
    repeat (40) begin
      bg = 2'($urandom);
      ba = 2'($urandom);
      cid = 3'($urandom);
      issue(($urandom & 1) ? CMD_RD : CMD_WR, 18'($urandom));
      chk(vld, 1'h1);
      chk(q_cmd, cmd);
      chk(q_bg, bg);
      chk(q_ba, ba);
      chk(q_cid, cid);
      chk(q_die, die);
      chk(chop, exp_chop(a));
      chk(ap, a[AP_BIT]);
      chk(q16_bg, {1'h0, bg[0]});
      chk(q16_cid, 3'h0);
    end
    issue(CMD_DES, 18'h0);
    chk(vld, 1'h0);
    // Second die of the dual-die part answers on its own select
    die = 1'h1;
    issue(CMD_RD, 18'h01000);
    chk(vld, 1'h1);
    chk(q_die, 1'h1);
    die = 1'h0;
    // Refresh to a new group, then a calibration command
    bg = bg + 2'h1;
    issue(CMD_REF, 18'h0);
    chk(q_bg, bg);
    chk(q_cmd, CMD_REF);
    issue(CMD_ZQ, 18'h0);
    chk(q_cmd, CMD_ZQ);
    // Activates carry row bits on the command pins
    repeat (6) begin
      bg = 2'($urandom);
      ba = 2'($urandom);
      issue(CMD_ACT, 18'($urandom));
      chk(q_cmd, CMD_ACT);
      chk(q_a[16:14], a[16:14]);
      chk(bk[{bg, ba}], 1'h1);
      issue(CMD_MRS, 18'($urandom));
      chk(mr, {bg, ba});
      chk(q16_mr, {1'h0, bg[0], ba});
    end
    issue(CMD_PRE, 18'h0);
    chk(bk[{bg, ba}], 1'h0);
    issue(CMD_PREA, 18'h00400);
    chk(bk, 18'h0);
    // Enable low with banks idle, then with a row open
    cke = 1'h0;
    wait3();
    chk(pwr, PWR_PPD);
    chk({cmd_en, ctl_en}, 2'h1);
    cke = 1'h1;
    wait3();
    chk({pwr, clk_en, cmd_en}, {PWR_ACTIVE, 2'h3});
    issue(CMD_ACT, 18'h0);
    cke = 1'h0;
    wait3();
    chk(pwr, PWR_APD);
    cke = 1'h1;
    wait3();
    issue(CMD_PREA, 18'h00400);
    // Self refresh entry needs the enable low on the same request
    cke = 1'h0;
    issue(CMD_SRE, 18'h0);
    wait3();
    chk({pwr, ctl_en, clk_en}, {PWR_SR, 2'h0});
    cke = 1'h1;
    wait3();
    chk(pwr, PWR_ACTIVE);
    // Reset in mid-run closes the open row
    issue(CMD_ACT, 18'h0);
    i_rst_n = 1'h0;
    wait3();
    i_rst_n = 1'h1;
    wait3();
    chk({pwr, bk}, {PWR_ACTIVE, 16'h0});
    end_sim();
  end
endmodule
